/* kcws_top.sv */
// Module: kernel clock selection, dividers and power-mode wake-up control
`timescale 1ns/1ps
module kcws_top (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire kcws_pkg::kcws_osc_type osc_tick,
    input  wire kcws_pkg::kcws_sel_type sel,
    input  wire logic                  lowpower_calibration_enable,
    input  wire logic                  lowpower_mode,
    input  wire logic [15:0]           system_clock_khz,
    input  wire logic                  enter_stop,
    input  wire logic                  enter_standby,
    input  wire logic                  enter_shutdown,
    input  wire logic                  stop_wake_clock_sel,
    input  wire logic [3:0]            standby_msi_mhz,
    input  wire logic [4:0]            wakeup_pin,
    input  wire logic [4:0]            wakeup_pin_enable,
    input  wire logic [4:0]            wakeup_pin_falling,
    input  wire logic                  calendar_event,
    input  wire logic                  external_reset_pin_n,
    input  wire logic                  independent_watchdog_reset,
    input  wire logic [15:0]           external_event_line,
    input  wire logic [13:0]           stop_wake_request,
    input  wire logic                  retain_ram_enable,
    input  wire logic                  pull_apply_enable,
    input  wire logic [15:0]           io_pull_up_sel,
    input  wire logic [15:0]           io_pull_down_sel,
    output kcws_pkg::kcws_kclk_type    kclk_tick,
    output kcws_pkg::kcws_pwr_type     power_state,
    output logic                       lowpower_calibration_active,
    output logic                       lp_system_clock_violation,
    output logic                       wake_clock_sel,
    output logic [3:0]                 wake_msi_mhz,
    output logic                       wake_done,
    output logic                       brownout_reset_enable,
    output logic                       retained_ram_keep,
    output logic [15:0]                io_pull_up,
    output logic [15:0]                io_pull_down
);

    // Four-way tick selector shared by every kernel mux
    function automatic logic pick4(input logic [1:0] s, input logic a, input logic b,
                                   input logic c, input logic d);
        unique case (s)
            2'h0:    pick4 = a;
            2'h1:    pick4 = b;
            2'h2:    pick4 = c;
            default: pick4 = d;
        endcase
    endfunction : pick4

    kcws_pkg::kcws_osc_type ot;
    kcws_pkg::kcws_kclk_type kclk_r;
    kcws_pkg::kcws_pwr_type  state_r;
    logic       usb_nxt, cal_src, usart_nxt, i2c_nxt, adc_src_tick, adc_k_nxt, adc_b_nxt;
    logic [4:0] hse_cnt_r;
    logic       hse32;
    logic [8:0] adc_kcnt_r;
    logic [8:0] adc_klim;
    logic [1:0] adc_bcnt_r;
    logic [1:0] adc_blim;
    logic       adc_bus_mode;

    assign ot = osc_tick;

    // Source muxes; selection changes assumed only with the consumer idle R20
    assign usb_nxt   = pick4(sel.usb_sel, ot.pll_usb_kernel_output, ot.multispeed_rc_osc,
                             ot.rc_48mhz_osc, 1'b0); // R1
    assign cal_src   = pick4(sel.cal_sel, ot.low_speed_crystal_osc, ot.low_speed_rc_osc,
                             hse32, 1'b0); // R3
    assign usart_nxt = pick4(sel.usart_sel, ot.system_clock, ot.rc_16mhz_osc,
                             ot.low_speed_crystal_osc, ot.apb); // R9
    assign i2c_nxt   = pick4(sel.i2c_sel, ot.system_clock, ot.rc_16mhz_osc,
                             ot.apb, 1'b0); // R10
    assign adc_src_tick = pick4(sel.adc_src, ot.system_clock, ot.pll_p_output,
                                ot.rc_16mhz_osc, 1'b0); // R6

    // Fixed divide-by-32 of the high-speed crystal for the calendar path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hse_cnt_r <= 5'h00;
        end else if (ot.high_speed_crystal_osc) begin
            hse_cnt_r <= hse_cnt_r + 5'h01; // R3
        end
    end
    assign hse32 = ot.high_speed_crystal_osc && (hse_cnt_r == 5'(kcws_pkg::HSE_CAL_DIV - 1));

    // ADC kernel divider: field n gives 2^n, capped at 256
    assign adc_klim = (sel.adc_kernel_divider > 4'(kcws_pkg::ADC_KDIV_MAX)) ? 9'h0ff :
                      9'((9'h001 << sel.adc_kernel_divider) - 9'h001); // R6
    assign adc_bus_mode = (sel.adc_bus_clock_divider != kcws_pkg::ADC_BUS_OFF);
    assign adc_blim = (sel.adc_bus_clock_divider == kcws_pkg::ADC_BUS_D1) ? 2'h0 :
                      (sel.adc_bus_clock_divider == kcws_pkg::ADC_BUS_D2) ? 2'h1 : 2'h3; // R7

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_kcnt_r <= 9'h000;
        end else if (adc_bus_mode) begin
            adc_kcnt_r <= 9'h000;
        end else if (adc_src_tick) begin
            adc_kcnt_r <= (adc_kcnt_r >= adc_klim) ? 9'h000 : adc_kcnt_r + 9'h001; // R6
        end
    end
    assign adc_k_nxt = adc_src_tick && (adc_kcnt_r >= adc_klim);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_bcnt_r <= 2'h0;
        end else if (!adc_bus_mode) begin
            adc_bcnt_r <= 2'h0;
        end else if (ot.apb) begin
            adc_bcnt_r <= (adc_bcnt_r >= adc_blim) ? 2'h0 : adc_bcnt_r + 2'h1; // R7
        end
    end
    assign adc_b_nxt = ot.apb && (adc_bcnt_r >= adc_blim);

    // Registered kernel ticks; calendar and LCD take the same one R2
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            kclk_r <= '0;
        end else begin
            kclk_r.usb             <= usb_nxt; // R1
            kclk_r.calendar_clock  <= cal_src; // R2
            kclk_r.adc             <= adc_bus_mode ? adc_b_nxt : adc_k_nxt; // R7
            kclk_r.dac_sample_hold <= ot.low_speed_rc_osc; // R8
            kclk_r.usart           <= usart_nxt; // R9
            kclk_r.i2c             <= i2c_nxt; // R10
        end
    end
    assign kclk_tick = kclk_r;

    // Calibration mode and low-power clock check; bus-vs-calendar ratio is software's R4
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lowpower_calibration_active <= 1'b0;
            lp_system_clock_violation         <= 1'b0;
        end else begin
            lowpower_calibration_active <= lowpower_calibration_enable; // R5
            lp_system_clock_violation <= lowpower_mode &&
                (system_clock_khz > 16'(kcws_pkg::LP_SYSTEM_CLOCK_MAX_KHZ)); // R11
        end
    end

    // Pin synchronisers; only the second stage and its delayed copy feed logic
    logic [6:0] pin_s1_r, pin_s2_r, pin_prev_r;
    logic [4:0] pin_edge;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_r   <= 7'h00;
            pin_s2_r   <= 7'h00;
            pin_prev_r <= 7'h00;
        end else begin
            pin_s1_r   <= {calendar_event, !external_reset_pin_n, wakeup_pin};
            pin_s2_r   <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end
    // Edge polarity chosen per pin
    genvar gi;
    generate
        for (gi = 0; gi < kcws_pkg::N_WAKE_PINS; gi++) begin : g_pin
            assign pin_edge[gi] = wakeup_pin_enable[gi] && (wakeup_pin_falling[gi] ?
                (pin_prev_r[gi] && !pin_s2_r[gi]) : (!pin_prev_r[gi] && pin_s2_r[gi])); // R15
        end
    endgenerate

    logic deep_wake, standby_wake, stop_wake;
    assign deep_wake    = (|pin_edge) || pin_s2_r[6] || pin_s2_r[5]; // R15
    assign standby_wake = deep_wake || independent_watchdog_reset; // R15
    assign stop_wake    = (|external_event_line) || (|stop_wake_request); // R16

    // Power-mode sequencer with wake-clock choice
    logic [9:0] wake_cnt_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r        <= kcws_pkg::PW_RUN;
            wake_clock_sel <= kcws_pkg::WAKE_CLK_MSI;
            wake_msi_mhz   <= kcws_pkg::SHUTDOWN_MSI_MHZ;
        end else begin
            unique case (state_r)
                kcws_pkg::PW_RUN: begin
                    if (enter_shutdown) begin
                        state_r <= kcws_pkg::PW_SHUTDOWN;
                    end else if (enter_standby) begin
                        state_r <= kcws_pkg::PW_STANDBY;
                    end else if (enter_stop) begin
                        state_r <= kcws_pkg::PW_STOP;
                    end
                end
                kcws_pkg::PW_STOP: begin
                    if (stop_wake) begin
                        state_r        <= kcws_pkg::PW_WAKE;
                        wake_clock_sel <= stop_wake_clock_sel; // R12
                    end
                end
                kcws_pkg::PW_STANDBY: begin
                    if (standby_wake) begin
                        state_r        <= kcws_pkg::PW_WAKE;
                        wake_clock_sel <= kcws_pkg::WAKE_CLK_MSI; // R13
                        wake_msi_mhz   <= (standby_msi_mhz < kcws_pkg::STANDBY_MSI_MIN) ?
                            kcws_pkg::STANDBY_MSI_MIN :
                            (standby_msi_mhz > kcws_pkg::STANDBY_MSI_MAX) ?
                            kcws_pkg::STANDBY_MSI_MAX : standby_msi_mhz; // R13
                    end
                end
                kcws_pkg::PW_SHUTDOWN: begin
                    if (deep_wake) begin
                        state_r        <= kcws_pkg::PW_WAKE;
                        wake_clock_sel <= kcws_pkg::WAKE_CLK_MSI; // R14
                        wake_msi_mhz   <= kcws_pkg::SHUTDOWN_MSI_MHZ; // R14
                    end
                end
                kcws_pkg::PW_WAKE: begin
                    if (wake_cnt_r == 10'(kcws_pkg::WAKE_CYCLES - 1)) begin
                        state_r <= kcws_pkg::PW_RUN;
                    end
                end
            endcase
        end
    end
    assign power_state = state_r;

    // Wake counter: oscillator restart only, no PLL lock wait
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_cnt_r <= 10'h000;
            wake_done  <= 1'b0;
        end else begin
            wake_cnt_r <= (state_r == kcws_pkg::PW_WAKE) ? wake_cnt_r + 10'h001 : 10'h000;
            wake_done  <= (state_r == kcws_pkg::PW_WAKE) &&
                          (wake_cnt_r == 10'(kcws_pkg::WAKE_CYCLES - 1)); // R12
        end
    end

    // Supervisor and standby retention outputs; brownout has no software off R17
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            brownout_reset_enable <= 1'b1;
            retained_ram_keep     <= 1'b0;
            io_pull_up            <= 16'h0000;
            io_pull_down          <= 16'h0000;
        end else begin
            brownout_reset_enable <= (state_r != kcws_pkg::PW_SHUTDOWN); // R17
            retained_ram_keep <= (state_r == kcws_pkg::PW_STANDBY) && retain_ram_enable; // R18
            io_pull_up   <= ((state_r == kcws_pkg::PW_STANDBY) && pull_apply_enable) ?
                            io_pull_up_sel : 16'h0000; // R18
            io_pull_down <= ((state_r == kcws_pkg::PW_STANDBY) && pull_apply_enable) ?
                            io_pull_down_sel : 16'h0000; // R19
        end
    end

    // Checks
    sequence s_stop_exit;
        state_r == kcws_pkg::PW_STOP && stop_wake ##1 state_r == kcws_pkg::PW_WAKE;
    endsequence
    sequence s_shut_exit;
        state_r == kcws_pkg::PW_SHUTDOWN && deep_wake ##1 state_r == kcws_pkg::PW_WAKE;
    endsequence

    a_usb_source: assert property (@(posedge clk) disable iff (!reset_n) // R1
        kclk_r.usb == $past(usb_nxt) || $past(!reset_n)) else $error("usb tick mismatch");
    a_cal_div32: assert property (@(posedge clk) disable iff (!reset_n) // R3
        hse32 |-> hse_cnt_r == 5'h1f) else $error("hse div32 wrong");
    a_lowpower_calibration_enable_follow: assert property (@(posedge clk) disable iff (!reset_n) // R5
        $rose(lowpower_calibration_enable) |=> lowpower_calibration_active)
        else $error("lowpower_calibration_enable not applied");
    a_adc_div1: assert property (@(posedge clk) disable iff (!reset_n) // R6
        !adc_bus_mode && sel.adc_kernel_divider == 4'h0 && adc_src_tick |=> kclk_r.adc)
        else $error("adc div1 missing tick");
    a_dac_lsi: assert property (@(posedge clk) disable iff (!reset_n) // R8
        ot.low_speed_rc_osc |=> kclk_r.dac_sample_hold) else $error("dac tick lost");
    a_stop_clock: assert property (@(posedge clk) disable iff (!reset_n) // R12
        s_stop_exit |-> wake_clock_sel == $past(stop_wake_clock_sel))
        else $error("stop wake clock wrong");
    a_wake_time: assert property (@(posedge clk) disable iff (!reset_n) // R12
        $rose(wake_done) |-> $past(state_r) == kcws_pkg::PW_WAKE &&
        state_r == kcws_pkg::PW_RUN) else $error("wake end wrong");
    a_shut_msi4: assert property (@(posedge clk) disable iff (!reset_n) // R14
        s_shut_exit |-> wake_msi_mhz == 4'h4 && wake_clock_sel) else $error("shutdown msi");
    a_bor_on: assert property (@(posedge clk) disable iff (!reset_n) // R17
        state_r == kcws_pkg::PW_STOP |=> brownout_reset_enable) else $error("bor off");

endmodule : kcws_top

/* kcws_pkg.sv */
// Package: constants, encodings and carrier types for kernel clock and wake-up select
// What this block does
// R1: USB clock from PLL, multispeed or 48 MHz RC
// R2: Calendar and LCD share one clock
// R3: Calendar clock: low-speed crystal, RC, or crystal/32
// R4: Software keeps bus clock at or above calendar
// R5: Low-power calibration bit switches calendar calibration mode
// R6: ADC kernel: source select, divide 1 to 256
// R7: ADC bus mode: bus clock divided 1,2,4
// R8: DAC sample-and-hold timed by low-speed RC
// R9: Serial port clock from four sources
// R10: I2C clock from three sources
// R11: Low-power modes cap system clock at 2 MHz
// R12: Stop exit restarts on 16 MHz or multispeed
// R13: Standby exit restarts multispeed at 1-8 MHz
// R14: Shutdown exit restarts multispeed at 4 MHz
// R15: Standby/shutdown wake: pins, calendar, reset; watchdog wakes standby only
// R16: Stop wakes on event lines or peripheral requests
// R17: Brownout always enabled except in shutdown
// R18: Standby optionally retains RAM and applies pulls
// R19: Power control bit groups exposed as ports
// R20: Software changes selections only while peripheral disabled
package kcws_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_TIME_NS  = 5000;
    localparam int WAKE_CYCLES   = WAKE_TIME_NS / CLK_PERIOD_NS;
    localparam int LP_SYSTEM_CLOCK_MAX_KHZ = 2000;
    localparam int HSE_CAL_DIV   = 32;
    localparam int ADC_KDIV_MAX  = 8;
    localparam int N_WAKE_PINS   = 5;
    localparam int N_STOP_SRC    = 14;
    localparam int N_EVENT_LINES = 16;
    localparam int N_IO          = 16;
    localparam logic [3:0] SHUTDOWN_MSI_MHZ = 4'h4;
    localparam logic [3:0] STANDBY_MSI_MIN  = 4'h1;
    localparam logic [3:0] STANDBY_MSI_MAX  = 4'h8;
    // Source encodings, two bits each; wake clock select one bit
    localparam logic [1:0] USB_PLL = 2'h0, USB_MSI = 2'h1, USB_RC48 = 2'h2;
    localparam logic [1:0] CAL_LSE = 2'h0, CAL_LSI = 2'h1, CAL_HSE = 2'h2;
    localparam logic [1:0] ADC_SYS = 2'h0, ADC_PLLP = 2'h1, ADC_RC16 = 2'h2;
    localparam logic [1:0] ADC_BUS_OFF = 2'h0, ADC_BUS_D1 = 2'h1, ADC_BUS_D2 = 2'h2;
    localparam logic [1:0] SER_SYS = 2'h0, SER_RC16 = 2'h1, SER_LSE = 2'h2, SER_APB = 2'h3;
    localparam logic [1:0] I2C_SYS = 2'h0, I2C_RC16 = 2'h1, I2C_APB = 2'h2;
    localparam logic WAKE_CLK_RC16 = 1'b0;
    localparam logic WAKE_CLK_MSI  = 1'b1;

    typedef enum logic [2:0] {PW_RUN, PW_STOP, PW_STANDBY, PW_SHUTDOWN, PW_WAKE} kcws_pwr_type;

    // One-cycle ticks, one per source clock edge
    typedef struct packed {
        logic system_clock;
        logic pll_usb_kernel_output;
        logic pll_p_output;
        logic multispeed_rc_osc;
        logic rc_48mhz_osc;
        logic rc_16mhz_osc;
        logic low_speed_crystal_osc;
        logic low_speed_rc_osc;
        logic high_speed_crystal_osc;
        logic apb;
    } kcws_osc_type;

    typedef struct packed {
        logic [1:0] usb_sel;
        logic [1:0] cal_sel;
        logic [1:0] adc_src;
        logic [3:0] adc_kernel_divider;
        logic [1:0] adc_bus_clock_divider;
        logic [1:0] usart_sel;
        logic [1:0] i2c_sel;
    } kcws_sel_type;

    typedef struct packed {
        logic usb;
        logic calendar_clock;
        logic adc;
        logic dac_sample_hold;
        logic usart;
        logic i2c;
    } kcws_kclk_type;
endpackage : kcws_pkg

/* kcws_periph_model.sv */
// Peripheral-side model: counts the kernel clock ticks that reach each consumer
`timescale 1ns/1ps
module kcws_periph_model (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    enable,
    input  wire kcws_pkg::kcws_kclk_type kclk,
    output logic [5:0][15:0]             tick_count
);
    // A disabled consumer forgets its count, so selections only move while it is off
    // The calendar count also stands for the glass display, which shares that tick
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_count <= '0;
        end else if (!enable) begin
            tick_count <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                tick_count[i] <= tick_count[i] + 16'(kclk[i]);
            end
        end
    end
endmodule : kcws_periph_model

/* tb_top.sv */
// Testbench: kernel clock routing, dividers and power-mode wake-up sequencing
`timescale 1ns/1ps
module tb_top;
    logic                    clk, reset_n, model_en;
    kcws_pkg::kcws_osc_type  osc_tick;
    kcws_pkg::kcws_sel_type  sel;
    kcws_pkg::kcws_kclk_type kclk_tick;
    kcws_pkg::kcws_pwr_type  power_state;
    logic                    lowpower_calibration_enable, lowpower_mode, stop_wake_clock_sel;
    logic                    enter_stop, enter_standby, enter_shutdown, calendar_event;
    logic                    external_reset_pin_n, independent_watchdog_reset;
    logic                    retain_ram_enable, pull_apply_enable, retained_ram_keep;
    logic                    lowpower_calibration_active, lp_system_clock_violation;
    logic                    wake_clock_sel, wake_done, brownout_reset_enable;
    logic [15:0]             system_clock_khz, external_event_line, io_pull_up_sel;
    logic [15:0]             io_pull_down_sel, io_pull_up, io_pull_down;
    logic [3:0]              standby_msi_mhz, wake_msi_mhz;
    logic [4:0]              wakeup_pin, wakeup_pin_enable, wakeup_pin_falling;
    logic [13:0]             stop_wake_request;
    logic [5:0][15:0]        tick_count;
    int                      fails, comparisons;

    kcws_top i_kcws_top (.clk, .reset_n, .osc_tick, .sel, .lowpower_calibration_enable,
        .lowpower_mode, .system_clock_khz, .enter_stop, .enter_standby, .enter_shutdown,
        .stop_wake_clock_sel, .standby_msi_mhz, .wakeup_pin, .wakeup_pin_enable,
        .wakeup_pin_falling, .calendar_event, .external_reset_pin_n,
        .independent_watchdog_reset, .external_event_line, .stop_wake_request,
        .retain_ram_enable, .pull_apply_enable, .io_pull_up_sel, .io_pull_down_sel,
        .kclk_tick, .power_state, .lowpower_calibration_active, .lp_system_clock_violation,
        .wake_clock_sel, .wake_msi_mhz, .wake_done, .brownout_reset_enable,
        .retained_ram_keep, .io_pull_up, .io_pull_down);

    kcws_periph_model i_kcws_periph_model (.clk, .reset_n, .enable(model_en),
        .kclk(kclk_tick), .tick_count);

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run();
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Inputs always move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Field f gets code v with the consumer off, then n source ticks are driven and the kernel ticks at kb counted
    task automatic krun(input int f, input logic [3:0] v, input int src, kb, n,
                        input logic [15:0] e);
        kcws_pkg::kcws_sel_type s;
        s = {2'h3, 2'h3, 2'h3, 4'h0, 2'h0, 2'h0, 2'h3};
        case (f)
            0: s.usb_sel = v[1:0];
            1: s.cal_sel = v[1:0];
            2: s.adc_src = v[1:0];
            3: {s.adc_src, s.adc_kernel_divider} = {2'h1, v};
            4: s.adc_bus_clock_divider = v[1:0];
            5: s.usart_sel = v[1:0];
            default: s.i2c_sel = v[1:0];
        endcase
        model_en = 1'b0;
        sel = s;
        cyc(2);
        model_en = 1'b1;
        repeat (n) begin
            osc_tick = kcws_pkg::kcws_osc_type'(10'h1 << src);
            cyc(1);
            osc_tick = '0;
            cyc(1);
        end
        cyc(2);
        chk("kernel tick count", e, tick_count[kb]);
    endtask : krun

    task automatic go(input logic [2:0] m);
        {enter_shutdown, enter_standby, enter_stop} = m;
        cyc(1);
        {enter_shutdown, enter_standby, enter_stop} = 3'h0;
    endtask : go

    task automatic wst(input kcws_pkg::kcws_pwr_type s);
        int k;
        k = 0;
        while (power_state !== s && k < 10) begin
            cyc(1);
            k++;
        end
        chk("power state", 16'(s), 16'(power_state));
        if (k == 10) complete_run();
    endtask : wst

    // Wake phase must last exactly 5 us at 100 MHz
    task automatic wake(input logic e_sel, input logic [3:0] e_msi);
        int k;
        wst(kcws_pkg::PW_WAKE);
        chk("wake clock select", 16'(e_sel), 16'(wake_clock_sel));
        chk("wake msi range", 16'(e_msi), 16'(wake_msi_mhz));
        k = 0;
        while (wake_done !== 1'b1 && k < 600) begin
            cyc(1);
            k++;
        end
        chk("wake length", 16'h1f4, 16'(k));
        chk("power state", 16'(kcws_pkg::PW_RUN), 16'(power_state));
        if (k == 600) complete_run();
    endtask : wake

    // Main sequence
    initial begin
        {reset_n, model_en, lowpower_calibration_enable, lowpower_mode} = 4'h0;
        {stop_wake_clock_sel, enter_stop, enter_standby, enter_shutdown} = 4'h0;
        {calendar_event, independent_watchdog_reset, retain_ram_enable} = 3'h0;
        {pull_apply_enable, external_reset_pin_n} = 2'h3;
        {osc_tick, sel, external_event_line, stop_wake_request} = '0;
        {io_pull_up_sel, io_pull_down_sel, standby_msi_mhz} = '0;
        system_clock_khz = 16'h07d0;
        wakeup_pin = 5'h1e;
        {wakeup_pin_enable, wakeup_pin_falling} = 10'h0;
        fails = 0;
        comparisons = 0;
        cyc(2);
        reset_n = 1'b1;
        chk("reset state", 16'(kcws_pkg::PW_RUN), 16'(power_state));
        chk("reset wake msi", 16'h4, 16'(wake_msi_mhz));
        chk("reset brownout", 16'h1, 16'(brownout_reset_enable));
        krun(0, 4'h0, 8, 5, 3, 16'h3);
        krun(0, 4'h1, 6, 5, 3, 16'h3);
        krun(0, 4'h2, 5, 5, 3, 16'h3);
        krun(0, 4'h1, 8, 5, 3, 16'h0);
        krun(0, 4'h3, 6, 5, 3, 16'h0);
        krun(1, 4'h0, 3, 4, 3, 16'h3);
        // Calendar ticks stay sparse, never outrunning the bus clock
        krun(1, 4'h1, 2, 4, 3, 16'h3);
        krun(1, 4'h2, 1, 4, 64, 16'h2);
        krun(1, 4'h2, 1, 4, 31, 16'h0);
        krun(1, 4'h3, 2, 2, 3, 16'h3);
        krun(2, 4'h0, 9, 3, 3, 16'h3);
        krun(2, 4'h1, 7, 3, 3, 16'h3);
        krun(2, 4'h2, 4, 3, 3, 16'h3);
        krun(2, 4'h3, 4, 3, 3, 16'h0);
        krun(3, 4'h2, 7, 3, 8, 16'h2);
        krun(3, 4'h9, 7, 3, 256, 16'h1);
        krun(4, 4'h1, 0, 3, 3, 16'h3);
        krun(4, 4'h2, 0, 3, 4, 16'h2);
        krun(4, 4'h3, 0, 3, 8, 16'h2);
        for (int i = 0; i < 4; i++) begin
            krun(5, 4'(i), (i == 0) ? 9 : (i == 1) ? 4 : (i == 2) ? 3 : 0, 1, 3, 16'h3);
        end
        krun(6, 4'h0, 9, 0, 3, 16'h3);
        krun(6, 4'h2, 0, 0, 3, 16'h3);
        krun(6, 4'h3, 4, 0, 3, 16'h0);
        lowpower_mode = 1'b1;
        krun(6, 4'h1, 4, 0, 3, 16'h3);
        osc_tick = kcws_pkg::kcws_osc_type'(10'h010);
        cyc(1);
        osc_tick = '0;
        chk("i2c tick", 16'h1, 16'(kclk_tick.i2c));
        cyc(1);
        chk("i2c tick", 16'h0, 16'(kclk_tick.i2c));
        chk("lp cap", 16'h0, 16'(lp_system_clock_violation));
        system_clock_khz = 16'h07d1;
        lowpower_calibration_enable = 1'b1;
        cyc(2);
        chk("lp cap", 16'h1, 16'(lp_system_clock_violation));
        chk("lp calibration", 16'h1, 16'(lowpower_calibration_active));
        lowpower_calibration_enable = 1'b0;
        cyc(2);
        chk("lp calibration", 16'h0, 16'(lowpower_calibration_active));
        // Each of the 14 stop wake requests in turn, then event line 15, alternating the restart clock
        for (int i = 0; i < 15; i++) begin
            stop_wake_clock_sel = i[0];
            go(3'h1);
            wst(kcws_pkg::PW_STOP);
            chk("stop brownout", 16'h1, 16'(brownout_reset_enable));
            if (i == 14) external_event_line = 16'h8000;
            else stop_wake_request = 14'h1 << i;
            wake(i[0], 4'h4);
            {external_event_line, stop_wake_request} = '0;
        end
        {retain_ram_enable, io_pull_up_sel, io_pull_down_sel} = {1'b1, 16'h00a5, 16'h5a00};
        standby_msi_mhz = 4'hc;
        go(3'h2);
        wst(kcws_pkg::PW_STANDBY);
        {external_event_line, stop_wake_request, enter_stop} = '1;
        cyc(6);
        chk("standby hold", 16'(kcws_pkg::PW_STANDBY), 16'(power_state));
        chk("ram keep", 16'h1, 16'(retained_ram_keep));
        chk("pull up", 16'h00a5, io_pull_up);
        chk("pull down", 16'h5a00, io_pull_down);
        chk("standby brownout", 16'h1, 16'(brownout_reset_enable));
        {external_event_line, stop_wake_request, enter_stop} = '0;
        independent_watchdog_reset = 1'b1;
        wake(1'b1, 4'h8);
        chk("ram keep", 16'h0, 16'(retained_ram_keep));
        go(3'h5);
        wst(kcws_pkg::PW_SHUTDOWN);
        cyc(6);
        chk("shutdown hold", 16'(kcws_pkg::PW_SHUTDOWN), 16'(power_state));
        chk("shutdown brownout", 16'h0, 16'(brownout_reset_enable));
        independent_watchdog_reset = 1'b0;
        {wakeup_pin_enable, wakeup_pin_falling} = {5'h04, 5'h04};
        wakeup_pin = 5'h1a;
        wake(1'b1, 4'h4);
        chk("run brownout", 16'h1, 16'(brownout_reset_enable));
        {wakeup_pin_enable, wakeup_pin_falling, standby_msi_mhz} = {5'h01, 5'h00, 4'h0};
        go(3'h2);
        wst(kcws_pkg::PW_STANDBY);
        wakeup_pin = 5'h1b;
        wake(1'b1, 4'h1);
        complete_run();
    end
endmodule : tb_top
